// ### src/mtpg_pkg.sv
// constants, types and helpers for the multi-touch pattern guard
// Summary of operation
// - per-input guard enables, bit 4 unused, reset clear
// - any guard enable disables sense input five
// - blocking enable bit 7, set at reset
// - flag at most N touches, hold accepted ones
// - after release reselect first N in scan order
// - bits 3:2 select limit of one to four
// - touches beyond limit set overflow flag
// - blocking uses full touch threshold
// - pattern detect enable bit 7, reset clear
// - threshold scale 12.5, 25, 37.5, 100 percent
// - active or standby threshold per input
// - count mode: qualifying count reaches mask popcount
// - pattern mode: every selected input qualifies
// - qualify: delta above threshold or noise
// - pattern event blocks all touches, sets flag
// - blocking lasts only while condition holds
// - flag cleared by host once condition gone
// - alert enable bit 0 gates active-low alert
// - pattern mask one bit per input, reset all ones
package mtpg_pkg;
    localparam int NUM_IN = 8;
    localparam int TH_W = 7;
    localparam int DL_W = 8;
    localparam int CNT_W = 4;

    localparam logic [7:0] ADDR_GUARD = 8'h29;
    localparam logic [7:0] ADDR_MULTI = 8'h2A;
    localparam logic [7:0] ADDR_PCFG = 8'h2B;
    localparam logic [7:0] ADDR_PMASK = 8'h2D;

    localparam logic [7:0] RST_GUARD = 8'h00;
    localparam logic [7:0] RST_MULTI = 8'h80;
    localparam logic [7:0] RST_PCFG = 8'h00;
    localparam logic [7:0] RST_PMASK = 8'hFF;

    localparam logic [7:0] MASK_GUARD = 8'hEF;
    localparam logic [7:0] MASK_MULTI = 8'h8C;
    localparam logic [7:0] MASK_PCFG = 8'h8F;
    localparam logic [7:0] MASK_PMASK = 8'hFF;

    localparam int BIT_BLK_EN = 7;
    localparam int BIT_LIMIT_LO = 2;
    localparam int BIT_PDET_EN = 7;
    localparam int BIT_PTH_LO = 2;
    localparam int BIT_PCMP = 1;
    localparam int BIT_PALERT = 0;
    localparam int IDX_FIVE = 4;

    localparam logic [1:0] PTH_12P5 = 2'h0;
    localparam logic [1:0] PTH_25 = 2'h1;
    localparam logic [1:0] PTH_37P5 = 2'h2;

    // gray along idle -> blocking -> latched
    typedef enum logic [1:0] {
        MTPG_IDLE = 2'h0,
        MTPG_BLOCKING = 2'h1,
        MTPG_LATCHED = 2'h3
    } mtpg_state_t;

    function automatic logic [CNT_W-1:0] popcount(input logic [NUM_IN-1:0] v);
        logic [CNT_W-1:0] c;
        c = '0;
        for (int i = 0; i < NUM_IN; i++) begin
            c = c + CNT_W'(v[i]);
        end
        return c;
    endfunction : popcount
endpackage : mtpg_pkg

// ### src/mtpg_top.sv
// touch blocking, pattern detection and signal guard per sensing cycle
`timescale 1ns/1ps
module mtpg_top #(
    parameter int NUM_IN = mtpg_pkg::NUM_IN,
    parameter int TH_W = mtpg_pkg::TH_W,
    parameter int DL_W = mtpg_pkg::DL_W
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic int_clr_i,
    input wire logic cycle_done_i,
    input wire logic [NUM_IN*DL_W-1:0] delta_i,
    input wire logic [NUM_IN*TH_W-1:0] thresh_i,
    input wire logic [TH_W-1:0] standby_thresh_i,
    input wire logic [NUM_IN-1:0] standby_sel_i,
    input wire logic [NUM_IN-1:0] noise_i,
    output logic [NUM_IN-1:0] touch_o,
    output logic [NUM_IN-1:0] guard_en_o,
    output logic sense_input_five_en_o,
    output logic pattern_blocking_o,
    output logic touch_overflow_flag_o,
    output logic pattern_event_flag_o,
    output logic alert_n_o
);
    // ---------------- register file ----------------
    logic [7:0] guard_enable;
    logic [7:0] multi_touch_config;
    logic [7:0] pattern_detect_config;
    logic [7:0] pattern_select_mask;
    logic [7:0] next_guard_enable;
    logic [7:0] next_multi_touch_config;
    logic [7:0] next_pattern_detect_config;
    logic [7:0] next_pattern_select_mask;
    logic [7:0] next_reg_rdata;

    always_comb begin
        next_guard_enable = guard_enable;
        next_multi_touch_config = multi_touch_config;
        next_pattern_detect_config = pattern_detect_config;
        next_pattern_select_mask = pattern_select_mask;
        if (reg_wr_i) begin
            case (reg_addr_i)
                mtpg_pkg::ADDR_GUARD: next_guard_enable = reg_wdata_i & mtpg_pkg::MASK_GUARD;
                mtpg_pkg::ADDR_MULTI: next_multi_touch_config = reg_wdata_i & mtpg_pkg::MASK_MULTI;
                mtpg_pkg::ADDR_PCFG: next_pattern_detect_config = reg_wdata_i & mtpg_pkg::MASK_PCFG;
                mtpg_pkg::ADDR_PMASK: next_pattern_select_mask = reg_wdata_i & mtpg_pkg::MASK_PMASK;
                default: next_guard_enable = guard_enable;
            endcase
        end
    end

    always_comb begin
        next_reg_rdata = reg_rdata_o;
        if (reg_rd_i) begin
            case (reg_addr_i)
                mtpg_pkg::ADDR_GUARD: next_reg_rdata = guard_enable;
                mtpg_pkg::ADDR_MULTI: next_reg_rdata = multi_touch_config;
                mtpg_pkg::ADDR_PCFG: next_reg_rdata = pattern_detect_config;
                mtpg_pkg::ADDR_PMASK: next_reg_rdata = pattern_select_mask;
                default: next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            guard_enable <= mtpg_pkg::RST_GUARD;
            multi_touch_config <= mtpg_pkg::RST_MULTI;
            pattern_detect_config <= mtpg_pkg::RST_PCFG;
            pattern_select_mask <= mtpg_pkg::RST_PMASK;
            reg_rdata_o <= 8'h00;
        end else begin
            guard_enable <= next_guard_enable;
            multi_touch_config <= next_multi_touch_config;
            pattern_detect_config <= next_pattern_detect_config;
            pattern_select_mask <= next_pattern_select_mask;
            reg_rdata_o <= next_reg_rdata;
        end
    end

    // ---------------- field decode ----------------
    logic blk_en;
    logic [1:0] limit_sel;
    logic [2:0] touch_limit;
    logic pdet_en;
    logic [1:0] pth_sel;
    logic pcmp_mode;
    logic palert_en;
    logic guard_active;

    assign blk_en = multi_touch_config[mtpg_pkg::BIT_BLK_EN];
    assign limit_sel = multi_touch_config[mtpg_pkg::BIT_LIMIT_LO +: 2];
    assign touch_limit = {1'b0, limit_sel} + 3'h1;
    assign pdet_en = pattern_detect_config[mtpg_pkg::BIT_PDET_EN];
    assign pth_sel = pattern_detect_config[mtpg_pkg::BIT_PTH_LO +: 2];
    assign pcmp_mode = pattern_detect_config[mtpg_pkg::BIT_PCMP];
    assign palert_en = pattern_detect_config[mtpg_pkg::BIT_PALERT];

    // guard pin takes over input five
    assign guard_active = |guard_enable;
    assign guard_en_o = guard_enable;
    assign sense_input_five_en_o = ~guard_active;

    // ---------------- per-input compare ----------------
    // truncating shifts: small thresholds may scale to zero
    function automatic logic [TH_W-1:0] scale_th(input logic [TH_W-1:0] th, input logic [1:0] sel);
        logic [TH_W-1:0] r;
        case (sel)
            mtpg_pkg::PTH_12P5: r = th >> 3;
            mtpg_pkg::PTH_25: r = th >> 2;
            mtpg_pkg::PTH_37P5: r = (th >> 2) + (th >> 3);
            default: r = th;
        endcase
        return r;
    endfunction : scale_th

    logic [NUM_IN-1:0] raw_touch;
    logic [NUM_IN-1:0] qualify;

    always_comb begin
        logic [TH_W-1:0] th;
        logic [DL_W-1:0] dl;
        th = '0;
        dl = '0;
        raw_touch = '0;
        qualify = '0;
        for (int i = 0; i < NUM_IN; i++) begin
            dl = delta_i[i*DL_W +: DL_W];
            th = standby_sel_i[i] ? standby_thresh_i : thresh_i[i*TH_W +: TH_W];
            raw_touch[i] = dl > DL_W'(th);
            qualify[i] = (dl > DL_W'(scale_th(th, pth_sel))) || noise_i[i];
        end
        // input five carries no touch under guard
        if (guard_active) begin
            raw_touch[mtpg_pkg::IDX_FIVE] = 1'b0;
            qualify[mtpg_pkg::IDX_FIVE] = 1'b0;
        end
    end

    // ---------------- pattern condition ----------------
    logic pattern_hit;
    logic mode_hit;

    always_comb begin
        if (pcmp_mode) begin
            mode_hit = (qualify & pattern_select_mask) == pattern_select_mask;
        end else begin
            mode_hit = mtpg_pkg::popcount(qualify) >= mtpg_pkg::popcount(pattern_select_mask);
        end
        // gated by enable; empty mask never hits
        pattern_hit = pdet_en && (|pattern_select_mask) && mode_hit;
    end

    // ---------------- pattern state ----------------
    mtpg_pkg::mtpg_state_t state;
    mtpg_pkg::mtpg_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            mtpg_pkg::MTPG_IDLE: begin
                // event judged once per sensing cycle
                if (cycle_done_i && pattern_hit) begin
                    next_state = mtpg_pkg::MTPG_BLOCKING;
                end
            end
            mtpg_pkg::MTPG_BLOCKING: begin
                if (cycle_done_i && !pattern_hit) begin
                    next_state = mtpg_pkg::MTPG_LATCHED;
                end
            end
            mtpg_pkg::MTPG_LATCHED: begin
                if (cycle_done_i && pattern_hit) begin
                    next_state = mtpg_pkg::MTPG_BLOCKING;
                end else if (int_clr_i) begin
                    next_state = mtpg_pkg::MTPG_IDLE;
                end
            end
            default: next_state = mtpg_pkg::MTPG_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= mtpg_pkg::MTPG_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ---------------- touch limiting ----------------
    logic [NUM_IN-1:0] limited;
    logic overflow_now;

    mtpg_touch_limit #(
        .NUM_IN(NUM_IN)
    ) u_limit (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .step_i(cycle_done_i),
        .enable_i(blk_en),
        .limit_i(touch_limit),
        .raw_i(raw_touch),
        .flagged_o(limited),
        .overflow_o(overflow_now)
    );

    // ---------------- outputs ----------------
    logic [NUM_IN-1:0] next_touch;
    logic next_ovf_flag;
    logic next_pat_flag;
    logic next_alert_n;
    logic blocking_next;

    always_comb begin
        blocking_next = next_state == mtpg_pkg::MTPG_BLOCKING;
        next_touch = touch_o;
        if (blocking_next) begin
            next_touch = '0;
        end else if (cycle_done_i) begin
            next_touch = limited;
        end
        next_ovf_flag = touch_overflow_flag_o;
        if (int_clr_i) begin
            next_ovf_flag = 1'b0;
        end
        if (cycle_done_i && overflow_now) begin
            next_ovf_flag = 1'b1;
        end
        // flag set from event to host clear
        next_pat_flag = next_state != mtpg_pkg::MTPG_IDLE;
        next_alert_n = ~(next_pat_flag && palert_en);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            touch_o <= '0;
            touch_overflow_flag_o <= 1'b0;
            pattern_event_flag_o <= 1'b0;
            pattern_blocking_o <= 1'b0;
            alert_n_o <= 1'b1;
        end else begin
            touch_o <= next_touch;
            touch_overflow_flag_o <= next_ovf_flag;
            pattern_event_flag_o <= next_pat_flag;
            pattern_blocking_o <= blocking_next;
            alert_n_o <= next_alert_n;
        end
    end
endmodule : mtpg_top

// ### src/mtpg_touch_limit.sv
// simultaneous-touch limiter holding the accepted inputs
`timescale 1ns/1ps
module mtpg_touch_limit #(
    parameter int NUM_IN = mtpg_pkg::NUM_IN
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic step_i,
    input wire logic enable_i,
    input wire logic [2:0] limit_i,
    input wire logic [NUM_IN-1:0] raw_i,
    output logic [NUM_IN-1:0] flagged_o,
    output logic overflow_o
);
    logic [NUM_IN-1:0] accepted;
    logic [NUM_IN-1:0] next_accepted;
    logic [mtpg_pkg::CNT_W-1:0] cnt;
    logic released;

    always_comb begin
        released = |(accepted & ~raw_i);
        next_accepted = accepted;
        cnt = '0;
        if (step_i) begin
            next_accepted = released ? '0 : accepted;
            cnt = mtpg_pkg::popcount(next_accepted);
            // add new touches up to limit
            for (int i = 0; i < NUM_IN; i++) begin
                if (raw_i[i] && !next_accepted[i] && cnt < mtpg_pkg::CNT_W'(limit_i)) begin
                    next_accepted[i] = 1'b1;
                    cnt = cnt + mtpg_pkg::CNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            accepted <= '0;
        end else begin
            accepted <= next_accepted;
        end
    end

    // disabled: pass every touch
    // enabled: the set chosen at this step, so flags never trail the touches
    assign flagged_o = enable_i ? next_accepted : raw_i;
    assign overflow_o = enable_i && (mtpg_pkg::popcount(raw_i) > mtpg_pkg::CNT_W'(limit_i));
endmodule : mtpg_touch_limit

// ### test/mtpg_chk.sv
// port assertions for the pattern guard
`timescale 1ns/1ps
module mtpg_chk #(parameter int NUM_IN = 8, parameter int TH_W = 7, parameter int DL_W = 8) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic int_clr_i,
    input wire logic cycle_done_i,
    input wire logic [NUM_IN-1:0] touch_o,
    input wire logic [NUM_IN-1:0] guard_en_o,
    input wire logic sense_input_five_en_o,
    input wire logic pattern_blocking_o,
    input wire logic touch_overflow_flag_o,
    input wire logic pattern_event_flag_o,
    input wire logic alert_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_gd; !guard_en_o[4] && (sense_input_five_en_o == (guard_en_o == '0)); endproperty
    a_gd: assert property (p_gd) else $error("guard bits wrong");
    property p_bt; pattern_blocking_o |-> touch_o == '0 && pattern_event_flag_o; endproperty
    a_bt: assert property (p_bt) else $error("touch while blocked");
    property p_bc; $changed(pattern_blocking_o) |-> $past(cycle_done_i); endproperty
    a_bc: assert property (p_bc) else $error("block moved off cycle");
    property p_tc; !cycle_done_i |=> $stable(touch_o); endproperty
    a_tc: assert property (p_tc) else $error("touch moved off cycle");
    property p_ps; pattern_event_flag_o && !int_clr_i |=> pattern_event_flag_o; endproperty
    a_ps: assert property (p_ps) else $error("pattern flag lost");
    property p_pf; $fell(pattern_event_flag_o) |-> $past(int_clr_i) && !$past(pattern_blocking_o); endproperty
    a_pf: assert property (p_pf) else $error("pattern flag cleared early");
    property p_os; touch_overflow_flag_o && !int_clr_i |=> touch_overflow_flag_o; endproperty
    a_os: assert property (p_os) else $error("overflow flag lost");
    // alert and flag are registered from the same next state, so alert is low only while the flag is set
    property p_al; !alert_n_o |-> pattern_event_flag_o || $past(pattern_event_flag_o); endproperty
    a_al: assert property (p_al) else $error("alert without flag");
endmodule : mtpg_chk
bind mtpg_top mtpg_chk #(.NUM_IN(NUM_IN), .TH_W(TH_W), .DL_W(DL_W)) i_mtpg_chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .int_clr_i(int_clr_i), .cycle_done_i(cycle_done_i), .touch_o(touch_o), .guard_en_o(guard_en_o),
    .sense_input_five_en_o(sense_input_five_en_o), .pattern_blocking_o(pattern_blocking_o),
    .touch_overflow_flag_o(touch_overflow_flag_o), .pattern_event_flag_o(pattern_event_flag_o),
    .alert_n_o(alert_n_o));

// ### test/mtpg_front.sv
// sensing front end model: per-cycle deltas, thresholds and noise
`timescale 1ns/1ps
module mtpg_front (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [15:0] code_i,
    input wire logic [7:0] noise_i,
    output logic done_o,
    output logic cycle_done_o,
    output logic [63:0] delta_o,
    output logic [55:0] thresh_o,
    output logic [6:0] sb_th_o,
    output logic [7:0] sb_sel_o,
    output logic [7:0] noise_o
);
    int seed = 32'h025142F9;
    int t;
    initial begin
        {done_o, cycle_done_o, delta_o, thresh_o, sb_th_o, sb_sel_o, noise_o} = '0;
        forever begin
            @(posedge clk_i);
            if (go_i) begin
                // slow as well as prompt answers
                repeat ({$random(seed)} % 3) @(negedge clk_i);
                @(negedge clk_i);
                // standby level below every active level
                sb_th_o = 7'(16 + {$random(seed)} % 48);
                sb_sel_o = 8'($random(seed));
                for (int i = 0; i < 8; i++) begin
                    t = 64 + {$random(seed)} % 64;
                    thresh_o[7*i+:7] = 7'(t);
                    if (code_i[2*i+1]) delta_o[8*i+:8] = 8'(t + 1 + {$random(seed)} % 64);
                    else delta_o[8*i+:8] = code_i[2*i] ? (sb_sel_o[i] ? 8'(sb_th_o) : 8'(t)) : 8'h00;
                end
                // values hold only in the strobe cycle
                {noise_o, cycle_done_o} = {noise_i, 1'b1};
                @(negedge clk_i);
                {delta_o, noise_o, cycle_done_o, done_o} = {~delta_o, ~noise_o, 2'h1};
                @(negedge clk_i);
                done_o = 1'b0;
            end
        end
    end
endmodule : mtpg_front

// ### test/tb_multi_touch_pattern_guard.sv
// bench: registers, touch limiting and pattern blocking
`timescale 1ns/1ps
module tb_multi_touch_pattern_guard;
    logic clk_i = 0;
    logic rstn_i = 0;
    logic wr = 0, rd = 0, clr = 0, go = 0, cd, dn, five, blk, ovf, pf, al_n, hit;
    logic [7:0] a = 0, d = 0, nz = 0, q, tch, gd, ss, ns, e, m, g, cfg;
    logic [15:0] c = 0, rc;
    logic [63:0] dl;
    logic [55:0] th;
    logic [6:0] st;
    int mismatches = 0, compares = 0, seed = 32'h025142F9;
    logic [7:0] ad [5] = '{8'h29, 8'h2A, 8'h2B, 8'h2D, 8'h2C};
    logic [7:0] rv [5] = '{8'h00, 8'h80, 8'h00, 8'hFF, 8'h00};
    logic [7:0] mk [5] = '{8'hEF, 8'h8C, 8'h8F, 8'hFF, 8'h00};
    mtpg_top i_mtpg_top (.clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(a),
        .reg_wdata_i(d), .reg_rdata_o(q), .int_clr_i(clr), .cycle_done_i(cd), .delta_i(dl), .thresh_i(th),
        .standby_thresh_i(st), .standby_sel_i(ss), .noise_i(ns), .touch_o(tch), .guard_en_o(gd),
        .sense_input_five_en_o(five), .pattern_blocking_o(blk), .touch_overflow_flag_o(ovf),
        .pattern_event_flag_o(pf), .alert_n_o(al_n));
    mtpg_front i_mtpg_front (.clk_i(clk_i), .go_i(go), .code_i(c), .noise_i(nz), .done_o(dn),
        .cycle_done_o(cd), .delta_o(dl), .thresh_o(th), .sb_th_o(st), .sb_sel_o(ss), .noise_o(ns));
    initial forever #12.5 clk_i = ~clk_i;
    task automatic chk(input logic [7:0] s, input logic [7:0] x);
        compares++;
        if (s !== x) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, s, x);
        end
    endtask : chk
    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    // op bits: write, read, flag clear
    task automatic bus(input logic [2:0] op, input logic [7:0] ba, input logic [7:0] bd);
        @(negedge clk_i);
        {wr, rd, clr, a, d} = {op, ba, bd};
        @(negedge clk_i);
        {wr, rd, clr} = 3'h0;
    endtask : bus
    // two identical cycles: the accepted set must hold on the repeat
    task automatic sense(input logic [15:0] sc, input logic [7:0] sn);
        {c, nz} = {sc, sn};
        repeat (2) begin
            @(negedge clk_i);
            go = 1'b1;
            @(negedge clk_i);
            go = 1'b0;
            for (int i = 0; !dn; i++) begin
                if (i == 8) begin
                    mismatches++;
                    stop_test();
                end
                @(posedge clk_i);
            end
        end
        @(negedge clk_i);
    endtask : sense
    function automatic logic [7:0] pick(input logic [15:0] pc, input int o);
        for (int i = 0; i < 8; i++)
            pick[i] = pc[2*i+o];
    endfunction : pick
    function automatic logic [7:0] first_n(input logic [7:0] r, input int n);
        int k;
        k = 0;
        first_n = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (r[i] && k < n) begin
                first_n[i] = 1'b1;
                k++;
            end
        end
    endfunction : first_n
    initial begin
        repeat (8) @(negedge clk_i);
        rstn_i = 1'b1;
        for (int i = 0; i < 5; i++) begin
            bus(3'h2, ad[i], 8'h00);
            chk(q, rv[i]);
            bus(3'h4, ad[i], 8'hFF);
            bus(3'h2, ad[i], 8'h00);
            chk(q, mk[i]);
            bus(3'h4, ad[i], rv[i]);
        end
        bus(3'h4, 8'h29, 8'hFF);
        chk(gd, 8'hEF);
        chk(8'(five), 8'h00);
        bus(3'h4, 8'h29, 8'h00);
        $display("test registers done");
        bus(3'h4, 8'h2A, 8'h84);
        sense(16'h0220, 8'h00);
        chk(tch, 8'h14);
        sense(16'h0222, 8'h00);
        chk(tch, 8'h14);
        chk(8'(ovf), 8'h01);
        sense(16'h002A, 8'h00);
        chk(tch, 8'h03);
        for (int j = 0; j < 24; j++) begin
            rc = 16'($random(seed));
            g = j[0] ? 8'($random(seed)) & 8'hEF : 8'h00;
            cfg = {j[1], 3'h0, 2'($random(seed)), 2'h0};
            bus(3'h4, 8'h29, g);
            bus(3'h4, 8'h2A, cfg);
            sense(16'h0000, 8'h00);
            bus(3'h1, 8'h00, 8'h00);
            e = pick(rc, 1);
            if (g != 8'h00) e[4] = 1'b0;
            sense(rc, 8'($random(seed)));
            chk(8'(five), 8'(g == 8'h00));
            chk(tch, cfg[7] ? first_n(e, cfg[3:2] + 1) : e);
            chk(8'(ovf), 8'(cfg[7] && ($countones(e) > cfg[3:2] + 1)));
        end
        $display("test limit done");
        bus(3'h4, 8'h29, 8'h00);
        bus(3'h4, 8'h2A, 8'h00);
        for (int j = 0; j < 32; j++) begin
            rc = 16'($random(seed));
            g = 8'($random(seed) & $random(seed));
            m = j[4] ? pick(rc, 1) : 8'($random(seed));
            if (m == 8'h00) m = 8'h01;
            e = pick(rc, 1) | g | (j[1:0] != 2'h3 ? pick(rc, 0) : 8'h00);
            hit = j[2] ? ((m & ~e) == 8'h00) : ($countones(e) >= $countones(m));
            bus(3'h4, 8'h2B, {1'b1, 3'h0, 2'(j), j[2], j[3]});
            bus(3'h4, 8'h2D, m);
            sense(rc, g);
            chk(8'(blk), 8'(hit));
            chk(tch, hit ? 8'h00 : pick(rc, 1));
            chk(8'(al_n), 8'(!(hit && j[3])));
            bus(3'h1, 8'h00, 8'h00);
            chk(8'(pf), 8'(hit));
            sense(16'h0000, 8'h00);
            chk(8'({blk, pf}), 8'({1'b0, hit}));
            bus(3'h1, 8'h00, 8'h00);
            chk(8'(pf), 8'h00);
        end
        bus(3'h4, 8'h2B, 8'h00);
        sense(16'hFFFF, 8'hFF);
        chk(8'({blk, pf}), 8'h00);
        chk(tch, 8'hFF);
        $display("test pattern done");
        stop_test();
    end
endmodule : tb_multi_touch_pattern_guard
